// >>> hdl/tfc_pkg.sv
// Constants, register map and state types shared by the timer force/compare control block
package tfc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FORCE    = 8'h00;
  localparam logic [7:0] ADDR_PIN_EN   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'h08;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FORCE_A_BIT   = 7;
  localparam int FORCE_B_BIT   = 6;
  localparam int WGM_LSB       = 0;  // config [3:0]
  localparam int BEH_A_LSB     = 4;  // config [5:4]
  localparam int BEH_B_LSB     = 6;  // config [7:6]
  localparam int IRQ_MATCH_A   = 0;
  localparam int IRQ_MATCH_B   = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_PIN_EN  = 8'h00;
  localparam logic [7:0]  RST_CONFIG  = 8'h00;
  localparam logic [1:0]  RST_IRQ     = 2'h0;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [7:0]  RST_TEMP    = 8'h00;

  // ----------------------------------------------------------------
  // Waveform settings that are not PWM
  // ----------------------------------------------------------------
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_A    = 4'h4;
  localparam logic [3:0] WGM_CTC_CAPT = 4'hC;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Compare output behaviour on a match
  typedef enum logic [1:0] {
    TFC_BEH_NONE   = 2'b00,
    TFC_BEH_TOGGLE = 2'b01,
    TFC_BEH_CLEAR  = 2'b10,
    TFC_BEH_SET    = 2'b11
  } tfc_beh_e;

  // Register selected by an address
  typedef enum logic [2:0] {
    TFC_REG_FORCE = 3'b000,
    TFC_REG_PIN   = 3'b001,
    TFC_REG_LOW   = 3'b010,
    TFC_REG_HIGH  = 3'b011,
    TFC_REG_CFG   = 3'b100,
    TFC_REG_STAT  = 3'b101,
    TFC_REG_MASK  = 3'b110,
    TFC_REG_NONE  = 3'b111
  } tfc_reg_e;

endpackage : tfc_pkg

// >>> hdl/tfc_cnt_if.sv
// Interface between the register front end and the 16-bit counter core
`timescale 1ns/1ps
`default_nettype none
interface tfc_cnt_if;
  logic        load;          // CPU write commits a 16-bit value
  logic [15:0] load_value;
  logic        clear_on_a;    // Clear on channel A match mode
  logic [15:0] counter_value;
  logic        match_a;       // Real match pulses, already blocked
  logic        match_b;

  modport ctrl (output load, output load_value, output clear_on_a,
                input counter_value, input match_a, input match_b);
  modport core (input load, input load_value, input clear_on_a,
                output counter_value, output match_a, output match_b);
endinterface : tfc_cnt_if
`default_nettype wire

// >>> hdl/tfc_counter.sv
// 16-bit counter core with compare detection and write blocking
`timescale 1ns/1ps
`default_nettype none
module tfc_counter
  import tfc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        timer_tick,
  input  wire logic [15:0] chan_a_compare_value,
  input  wire logic [15:0] chan_b_compare_value,
  tfc_cnt_if.core          cnt
);

  typedef struct packed {
    logic [15:0] value;
    logic        block;  // Set by a CPU write, consumed by the next tick
  } tfc_cnt_s;

  tfc_cnt_s s;
  tfc_cnt_s next_s;
  logic     raw_a;
  logic     raw_b;

  // Raw equality, only meaningful on a timer tick
  assign raw_a = timer_tick && (s.value == chan_a_compare_value);
  assign raw_b = timer_tick && (s.value == chan_b_compare_value);

  assign cnt.match_a = raw_a && !s.block;
  assign cnt.match_b = raw_b && !s.block;
  assign cnt.counter_value = s.value;

  // Next state: a CPU load wins over a tick in the same cycle
  always_comb begin
    next_s = s;
    if (cnt.load) begin
      next_s.value = cnt.load_value;
      // Arm the block even when stopped
      next_s.block = 1'b1;
    end else if (timer_tick) begin
      next_s.block = 1'b0;
      if (cnt.clear_on_a && cnt.match_a) begin
        next_s.value = RST_COUNTER;
      end else begin
        next_s.value = s.value + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '{value: RST_COUNTER, block: 1'b0};
    end else begin
      s <= next_s;
    end
  end

endmodule // tfc_counter
`default_nettype wire

// >>> hdl/tfc_top.sv
// Force-compare control, pin enables and counter byte access behind AXI4-Lite
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tfc_top
  import tfc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer side
  input  wire logic        timer_tick,
  input  wire logic [15:0] chan_a_compare_value,
  input  wire logic [15:0] chan_b_compare_value,
  output logic [3:0]       chan_a_pins,
  output logic [3:0]       chan_b_pins,
  output logic [3:0]       chan_a_pin_active,
  output logic [3:0]       chan_b_pin_active,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  pin_en;   // compare_pin_enables
    logic [7:0]  config_r; // waveform_gen_setting and output behaviours
    logic [7:0]  temp;     // Shared temporary high byte
    logic        oc_a;     // Internal compare output state
    logic        oc_b;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
  } tfc_top_s;

  tfc_top_s  s;
  tfc_top_s  next_s;
  tfc_cnt_if cnt_if ();

  logic [3:0] waveform_gen_setting;
  logic [1:0] compare_output_behaviour_a;
  logic [1:0] compare_output_behaviour_b;
  logic       non_pwm;
  logic       do_write;
  logic       ar_take;
  logic [7:0] wbyte;
  tfc_reg_e   wsel;
  tfc_reg_e   rsel;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address decode, shared by both channels of the bus
  function automatic tfc_reg_e reg_of(input logic [7:0] a);
    if (a == ADDR_FORCE) begin
      return TFC_REG_FORCE;
    end else if (a == ADDR_PIN_EN) begin
      return TFC_REG_PIN;
    end else if (a == ADDR_CNT_LOW) begin
      return TFC_REG_LOW;
    end else if (a == ADDR_CNT_HIGH) begin
      return TFC_REG_HIGH;
    end else if (a == ADDR_CONFIG) begin
      return TFC_REG_CFG;
    end else if (a == ADDR_IRQ_STAT) begin
      return TFC_REG_STAT;
    end else if (a == ADDR_IRQ_MASK) begin
      return TFC_REG_MASK;
    end else begin
      return TFC_REG_NONE;
    end
  endfunction

  // Output state after a match, real or forced
  function automatic logic apply_beh(input logic cur, input logic [1:0] beh);
    case (tfc_beh_e'(beh))
      TFC_BEH_TOGGLE: return !cur;
      TFC_BEH_CLEAR:  return 1'b0;
      TFC_BEH_SET:    return 1'b1;
      default:        return cur;
    endcase
  endfunction

  assign waveform_gen_setting       = s.config_r[WGM_LSB +: 4];
  assign compare_output_behaviour_a = s.config_r[BEH_A_LSB +: 2];
  assign compare_output_behaviour_b = s.config_r[BEH_B_LSB +: 2];
  assign non_pwm = (waveform_gen_setting == WGM_NORMAL) ||
                   (waveform_gen_setting == WGM_CTC_A) ||
                   (waveform_gen_setting == WGM_CTC_CAPT);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // Address and data are taken independently; neither while a response waits
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;

  assign do_write = s.aw_got && s.w_got;
  assign ar_take  = s_axi_arvalid && !s.rvalid;
  assign wsel     = reg_of(s.aw_addr);
  assign rsel     = reg_of(s_axi_araddr);
  assign wbyte    = s.w_data[7:0];

  // ----------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------
  // Low byte write commits temp as the high byte
  assign cnt_if.load       = do_write && (wsel == TFC_REG_LOW) && s.w_strb[0];
  assign cnt_if.load_value = {s.temp, wbyte};
  // Forced matches never reach this path, so they cannot clear the counter
  assign cnt_if.clear_on_a = (waveform_gen_setting == WGM_CTC_A);

  tfc_counter u_counter (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .timer_tick           (timer_tick),
    .chan_a_compare_value (chan_a_compare_value),
    .chan_b_compare_value (chan_b_compare_value),
    .cnt                  (cnt_if.core)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Collect write address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Real compare matches change the outputs and latch events
    if (cnt_if.match_a) begin
      next_s.oc_a = apply_beh(s.oc_a, compare_output_behaviour_a);
    end
    if (cnt_if.match_b) begin
      next_s.oc_b = apply_beh(s.oc_b, compare_output_behaviour_b);
    end

    // Register write, one cycle after both halves are held
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = (wsel == TFC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (s.w_strb[0]) begin
        case (wsel)
          TFC_REG_FORCE: begin
            // Strobes honoured in non-PWM modes only
            if (non_pwm) begin
              if (wbyte[FORCE_A_BIT]) begin
                next_s.oc_a = apply_beh(s.oc_a, compare_output_behaviour_a);
              end
              if (wbyte[FORCE_B_BIT]) begin
                next_s.oc_b = apply_beh(s.oc_b, compare_output_behaviour_b);
              end
            end
          end
          TFC_REG_PIN:  next_s.pin_en = wbyte;
          TFC_REG_HIGH: next_s.temp = wbyte;
          TFC_REG_CFG:  next_s.config_r = wbyte;
          TFC_REG_MASK: next_s.irq_mask = wbyte[1:0];
          TFC_REG_STAT: next_s.irq_stat = s.irq_stat & ~wbyte[1:0];
          default: begin
          end
        endcase
      end
    end

    // Only real matches set status; set wins over clear
    if (cnt_if.match_a) begin
      next_s.irq_stat[IRQ_MATCH_A] = 1'b1;
    end
    if (cnt_if.match_b) begin
      next_s.irq_stat[IRQ_MATCH_B] = 1'b1;
    end

    // Register read, answered at the edge that takes the address
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      if (rsel == TFC_REG_FORCE) begin
        next_s.rdata = 32'h0000_0000;
      end else if (rsel == TFC_REG_PIN) begin
        next_s.rdata[7:0] = s.pin_en;
      end else if (rsel == TFC_REG_LOW) begin
        next_s.rdata[7:0] = cnt_if.counter_value[7:0];
        next_s.temp = cnt_if.counter_value[15:8];
      end else if (rsel == TFC_REG_HIGH) begin
        next_s.rdata[7:0] = s.temp;
      end else if (rsel == TFC_REG_CFG) begin
        next_s.rdata[7:0] = s.config_r;
      end else if (rsel == TFC_REG_STAT) begin
        next_s.rdata[1:0] = s.irq_stat;
      end else if (rsel == TFC_REG_MASK) begin
        next_s.rdata[1:0] = s.irq_mask;
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '{aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_data: 32'h0000_0000,
             w_strb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
             rresp: RESP_OKAY, rdata: 32'h0000_0000, pin_en: RST_PIN_EN,
             config_r: RST_CONFIG, temp: RST_TEMP, oc_a: 1'b0, oc_b: 1'b0,
             irq_stat: RST_IRQ, irq_mask: RST_IRQ};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------
  // Each pin is gated by its own enable, so one channel can feed any subset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign chan_a_pins[gi]       = s.oc_a & s.pin_en[gi];
      assign chan_a_pin_active[gi] = s.pin_en[gi] & (compare_output_behaviour_a != TFC_BEH_NONE);
      assign chan_b_pins[gi]       = s.oc_b & s.pin_en[gi+4];
      assign chan_b_pin_active[gi] = s.pin_en[gi+4] & (compare_output_behaviour_b != TFC_BEH_NONE);
    end
  endgenerate

  // Level interrupt while any unmasked event is pending
  assign irq = |(s.irq_stat & s.irq_mask);

endmodule // tfc_top
`default_nettype wire

// >>> tb/tfc_top_asserts.sv
// Port-level assertions for the timer force/compare control block
`timescale 1ns/1ps
`default_nettype none
module tfc_top_asserts
  import tfc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_tick,
  input wire logic [3:0]  chan_a_pins,
  input wire logic [3:0]  chan_b_pins,
  input wire logic [3:0]  chan_a_pin_active,
  input wire logic [3:0]  chan_b_pin_active,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  // No write offered or held: a held write is applied one edge after it is taken
  sequence wr_idle; s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid; endsequence
  // No write in flight and no timer clock: nothing may move
  sequence all_quiet; s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid && !timer_tick; endsequence

  // Readies drop at once; the response follows the apply edge
  AST_WR_ANSWER: assert property (wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response late or readies still high");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not presented one cycle after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  AST_FORCE_READ_ZERO: assert property (rd_take ##0 (s_axi_araddr == ADDR_FORCE) |=> s_axi_rdata == 32'h0)
    else $error("force strobe register read back nonzero");
  AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits nonzero");
  // A strobe leaves nothing behind that could act again later
  AST_PINS_QUIET: assert property (all_quiet |=> $stable(chan_a_pins) && $stable(chan_b_pins))
    else $error("pins moved without a write or tick");
  AST_ACTIVE_QUIET: assert property (wr_idle |=> $stable({chan_b_pin_active, chan_a_pin_active}))
    else $error("pin source select moved without a write");
  // The strobe acts at the edge after the take, so the interrupt is watched one edge later
  AST_FORCE_NO_IRQ: assert property (wr_take ##0 (s_axi_awaddr == ADDR_FORCE) ##1 !timer_tick |=> $stable(irq))
    else $error("forced match changed the interrupt");
  AST_IRQ_QUIET: assert property (all_quiet |=> $stable(irq))
    else $error("interrupt moved without a write or tick");
endmodule // tfc_top_asserts

bind tfc_top tfc_top_asserts tfc_top_asserts_inst (
  .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_tick(timer_tick), .chan_a_pins(chan_a_pins), .chan_b_pins(chan_b_pins),
  .chan_a_pin_active(chan_a_pin_active), .chan_b_pin_active(chan_b_pin_active), .irq(irq)
);
`default_nettype wire

// >>> tb/tfc_top_tb.sv
// Self-checking testbench for the timer force/compare control block
`timescale 1ns/1ps
`default_nettype none
module tfc_top_tb
  import tfc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tfc_row_s;
  // Plain register traffic; the last row is an unmapped address
  localparam tfc_row_s ROWS [6] = '{
    '{ADDR_PIN_EN, 32'hFFFFFFAB, RESP_OKAY, 32'h000000AB, RESP_OKAY},
    '{ADDR_FORCE, 32'h000000C0, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{ADDR_CONFIG, 32'h000000F4, RESP_OKAY, 32'h000000F4, RESP_OKAY},
    '{ADDR_IRQ_MASK, 32'h00000003, RESP_OKAY, 32'h00000003, RESP_OKAY},
    '{ADDR_CNT_HIGH, 32'h00000056, RESP_OKAY, 32'h00000056, RESP_OKAY},
    '{8'h1C, 32'h000000FF, RESP_SLVERR, 32'h00000000, RESP_SLVERR}};
  localparam logic [7:0] RST_ADDRS [5] = '{ADDR_PIN_EN, ADDR_CNT_LOW, ADDR_CNT_HIGH, ADDR_IRQ_STAT, ADDR_IRQ_MASK};

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        timer_tick = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  pins_a, pins_b, act_a, act_b;
  logic [1:0]  resp;
  logic [31:0] rd_val;
  int          errors = 0;
  int          total_checks = 0;

  always #50 mclk = ~mclk;

  tfc_top tfc_top_inst (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_tick(timer_tick),
    .chan_a_compare_value(16'h1234), .chan_b_compare_value(16'hFFFF), .chan_a_pins(pins_a),
    .chan_b_pins(pins_b), .chan_a_pin_active(act_a), .chan_b_pin_active(act_b), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Summary: %0d checks, %0d mismatches", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master: ready for the answer from the start, no assumed latency
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (++n > 50) begin
        errors++;
        wrap_up();
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (++n > 50) begin
        errors++;
        wrap_up();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd_val, resp);
    chk(n, e, rd_val);
  endtask

  // One timer clock, a single mclk cycle wide
  task automatic tick();
    @(posedge mclk) timer_tick <= 1'b1;
    @(posedge mclk) timer_tick <= 1'b0;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values
    foreach (RST_ADDRS[i]) rd("reset value", RST_ADDRS[i], 32'h0);
    chk("reset pins", 32'h0, {24'h0, pins_b, pins_a});
    chk("reset irq", 32'h0, {31'h0, irq});
    $display("Test reset done");
    // Ordinary register rows
    foreach (ROWS[i]) begin
      axi_write(ROWS[i].addr, ROWS[i].wdata, resp);
      chk("row bresp", {30'h0, ROWS[i].bresp}, {30'h0, resp});
      axi_read(ROWS[i].addr, rd_val, resp);
      chk("row rdata", ROWS[i].rdata, rd_val);
      chk("row rresp", {30'h0, ROWS[i].rresp}, {30'h0, resp});
    end
    $display("Test register rows done");
    // Forced matches in normal mode: A sets, B toggles
    wr(ADDR_PIN_EN, 32'hFF);
    wr(ADDR_CONFIG, 32'h70);
    wr(ADDR_FORCE, 32'h80);
    chk("force a set", 32'hF0F, {20'h0, act_a, pins_b, pins_a});
    wr(ADDR_FORCE, 32'h40);
    chk("force b toggle on", 32'hF, {28'h0, pins_b});
    wr(ADDR_FORCE, 32'h40);
    chk("force b toggle off", 32'h0, {28'h0, pins_b});
    // Per-pin enables mask each channel
    wr(ADDR_PIN_EN, 32'h3C);
    wr(ADDR_CONFIG, 32'hF0);
    wr(ADDR_FORCE, 32'h40);
    chk("pin enables", 32'h3C, {24'h0, pins_b, pins_a});
    chk("pin active", 32'h3C, {24'h0, act_b, act_a});
    // A PWM setting ignores the strobe
    wr(ADDR_CONFIG, 32'h21);
    wr(ADDR_FORCE, 32'h80);
    chk("pwm no force", 32'hC, {28'h0, pins_a});
    // Compatible software writes zero strobes while in a PWM setting
    wr(ADDR_FORCE, 32'h00);
    chk("pwm zero strobes", 32'hC, {28'h0, pins_a});
    // Clear-on-match mode: strobe clears pin, counter untouched
    wr(ADDR_CNT_HIGH, 32'h00);
    wr(ADDR_CNT_LOW, 32'h55);
    wr(ADDR_CONFIG, 32'h24);
    wr(ADDR_FORCE, 32'h80);
    chk("ctc force clear", 32'h0, {28'h0, pins_a});
    rd("counter kept", ADDR_CNT_LOW, 32'h55);
    rd("no status", ADDR_IRQ_STAT, 32'h0);
    chk("no irq", 32'h0, {31'h0, irq});
    $display("Test force strobes done");
    // Counter write equal to compare value: next tick blocked
    wr(ADDR_CNT_HIGH, 32'h12);
    wr(ADDR_CNT_LOW, 32'h34); // timer idle while written
    tick();
    rd("blocked low", ADDR_CNT_LOW, 32'h35);
    rd("latched high", ADDR_CNT_HIGH, 32'h12);
    rd("blocked status", ADDR_IRQ_STAT, 32'h0);
    // One tick later the block has lapsed and the match clears the counter
    wr(ADDR_CNT_HIGH, 32'h12);
    wr(ADDR_CNT_LOW, 32'h33);
    tick();
    tick();
    rd("match cleared", ADDR_CNT_LOW, 32'h0);
    rd("match status", ADDR_IRQ_STAT, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_IRQ_STAT, 32'h1);
    rd("status cleared", ADDR_IRQ_STAT, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("Test counter blocking done");
    wrap_up();
  end
endmodule // tfc_top_tb
`default_nettype wire
